// ==== motor_overheat_supervisor.sv ====
/*
  Motor overheat supervisor: filters the thermistor chain voltage, compares
  it with warning and fault levels, picks the stop style and vets settings.
  Assumes sense samples and setting writes are synchronous to clk.
*/
// Overview of operation
// - Above 0.94 V: flash warning, keep running
// - Above 1.87 V: fault, flash, stop per selection
// - Selection 0: no thermistor detection
// - Selection 1: warning only, never stop
// - Selection 2: warn, decelerate, fault output
// - Selection 3: as 2, second decel time
// - Selection 4: warn, coast, fault output
// - Selections 5-7: no warning, stop on fault
// - Protection on: sense not reference nor feedback
// - Protection on: refuse reference source 2-4
// - Protection plus PID: refuse feedback 0-2
// - Refuse protection 1 in conflicting combination
// - Panel refusal: show error, keep old value
// - Serial refusal: conflict error, flash panel
module motor_overheat_supervisor
  import overheat_pkg::*;
(
  input wire logic clk, // 100 MHz clock
  input wire logic reset, // Synchronous, active high
  input wire logic [SAMPLE_W-1:0] overheat_sense_input, // Digitised sense voltage
  input wire logic set_write, // One-cycle setting write strobe
  input wire logic set_from_serial, // High: write came over the serial link
  input wire logic [1:0] set_id, // Which setting is written
  input wire logic [SETTING_W-1:0] set_value, // New value
  input wire logic [6:0] set_filter_time, // Filter time in 0.1 s steps
  input wire logic set_filter_write, // Filter time write strobe
  input wire logic error_clear, // Clears the conflict flags
  output logic overheat_warning_indication, // Flashing warning indicator
  output logic overheat_fault_indication, // Flashing fault indicator
  output logic warning_active, // Warning level state
  output logic fault_output, // Fault output, latched until reset
  output logic [1:0] stop_style, // stop_style_t of the stop demanded
  output logic panel_error, // Panel write was refused
  output logic setting_conflict_error, // Serial write was refused, flashing
  output logic sense_as_freq_ref, // Sense usable as frequency reference
  output logic sense_as_pid_fb, // Sense usable as PID feedback
  output logic [SETTING_W-1:0] overheat_protect_select, // Held selection
  output logic [SETTING_W-1:0] freq_ref_source_select, // Held reference source
  output logic [SETTING_W-1:0] pid_control_select, // Held PID control
  output logic [SETTING_W-1:0] pid_feedback_source_select, // Held feedback source
  output logic [6:0] overheat_filter_time // Held filter time
);
  logic [SAMPLE_W-1:0] filtered;
  logic [31:0] step_count;
  logic [31:0] next_step_count;
  logic step;
  logic next_step;
  logic [2:0] flash_count;
  logic [2:0] next_flash_count;
  logic flash;
  logic next_flash;

  // Analog sources on the sense terminal
  function automatic logic is_analog_src(input logic [SETTING_W-1:0] v, input logic lo);
    is_analog_src = lo ? (v <= 4'h2) : (v >= 4'h2 && v <= 4'h4);
  endfunction : is_analog_src

  // Tick generator, one step per 0.1 s, and flash clock
  always_comb begin
    next_step_count = step_count + 32'h0000_0001;
    next_step = 1'b0;
    next_flash_count = flash_count;
    next_flash = flash;
    if (step_count == 32'(FILTER_STEP_CYCLES - 1)) begin
      next_step_count = '0;
      next_step = 1'b1;
      next_flash_count = flash_count + 3'h1;
      if (flash_count == FLASH_TICKS - 3'h1) begin
        next_flash_count = '0;
        next_flash = ~flash;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      step_count <= '0;
      step <= 1'b0;
      flash_count <= '0;
      flash <= 1'b0;
    end else begin
      step_count <= next_step_count;
      step <= next_step;
      flash_count <= next_flash_count;
      flash <= next_flash;
    end
  end

  // Filter the sense input before comparison
  overheat_filter u_filter (
    .clk(clk),
    .reset(reset),
    .step(step),
    .sample(overheat_sense_input),
    .time_const(overheat_filter_time),
    .filtered(filtered)
  );

  // Setting state with consistency checks
  logic [SETTING_W-1:0] next_prot;
  logic [SETTING_W-1:0] next_fref;
  logic [SETTING_W-1:0] next_pidc;
  logic [SETTING_W-1:0] next_pidfb;
  logic [6:0] next_ftime;
  logic refuse;
  logic next_panel_error;
  logic next_conflict;

  always_comb begin
    next_prot = overheat_protect_select;
    next_fref = freq_ref_source_select;
    next_pidc = pid_control_select;
    next_pidfb = pid_feedback_source_select;
    next_ftime = overheat_filter_time;
    refuse = 1'b0;
    if (set_filter_write && set_filter_time <= 7'(FILTER_TIME_MAX)) begin
      next_ftime = set_filter_time;
    end
    if (set_write) begin
      unique case (set_id)
        SET_PROTECT: begin
          // Protection 1 forbidden with analog reference plus analog PID feedback
          refuse = set_value == PROT_WARN_ONLY && is_analog_src(freq_ref_source_select, 1'b0)
            && pid_control_select == 4'h1
            && is_analog_src(pid_feedback_source_select, 1'b1);
          if (set_value > PROT_QUIET_COAST) refuse = 1'b1;
        end
        SET_FREQ_REF: refuse = overheat_protect_select != PROT_OFF
          && is_analog_src(set_value, 1'b0);
        SET_PID_CTRL: refuse = 1'b0;
        SET_PID_FB: refuse = overheat_protect_select != PROT_OFF
          && pid_control_select != 4'h0 && is_analog_src(set_value, 1'b1);
      endcase
      // Refused write leaves the held value untouched
      if (!refuse) begin
        unique case (set_id)
          SET_PROTECT: next_prot = set_value;
          SET_FREQ_REF: next_fref = set_value;
          SET_PID_CTRL: next_pidc = set_value;
          SET_PID_FB: next_pidfb = set_value;
        endcase
      end
    end
    // New refusals win over a clear in the same cycle
    next_panel_error = (panel_error && !error_clear)
      || (set_write && refuse && !set_from_serial);
    next_conflict = (setting_conflict_error && !error_clear)
      || (set_write && refuse && set_from_serial);
  end

  logic conflict_held;

  always_ff @(posedge clk) begin
    if (reset) begin
      overheat_protect_select <= PROT_RESET;
      freq_ref_source_select <= FREQ_REF_RESET;
      pid_control_select <= PID_CTRL_RESET;
      pid_feedback_source_select <= PID_FB_RESET;
      overheat_filter_time <= FILTER_TIME_RESET;
      panel_error <= 1'b0;
      conflict_held <= 1'b0;
    end else begin
      overheat_protect_select <= next_prot;
      freq_ref_source_select <= next_fref;
      pid_control_select <= next_pidc;
      pid_feedback_source_select <= next_pidfb;
      overheat_filter_time <= next_ftime;
      panel_error <= next_panel_error;
      conflict_held <= next_conflict;
    end
  end

  // Detection and response
  logic next_warning;
  logic next_fault;
  logic [1:0] next_stop;
  logic warn_shown;

  always_comb begin
    next_warning = 1'b0;
    next_fault = fault_output;
    next_stop = stop_style;
    warn_shown = 1'b0;
    unique case (overheat_protect_select)
      PROT_OFF: ;
      PROT_WARN_ONLY: warn_shown = 1'b1;
      PROT_DECEL, PROT_DECEL2, PROT_COAST: warn_shown = 1'b1;
      default: warn_shown = 1'b0;
    endcase
    if (overheat_protect_select != PROT_OFF) begin
      next_warning = warn_shown && filtered > WARN_LEVEL;
      if (filtered > FAULT_LEVEL && overheat_protect_select != PROT_WARN_ONLY
          && !fault_output) begin
        next_fault = 1'b1;
        unique case (overheat_protect_select)
          PROT_DECEL, PROT_QUIET_DECEL: next_stop = STOP_DECEL;
          PROT_DECEL2, PROT_QUIET_DECEL2: next_stop = STOP_DECEL2;
          default: next_stop = STOP_COAST;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      warning_active <= 1'b0;
      fault_output <= 1'b0;
      stop_style <= STOP_NONE;
      overheat_warning_indication <= 1'b0;
      overheat_fault_indication <= 1'b0;
      setting_conflict_error <= 1'b0;
      sense_as_freq_ref <= 1'b0;
      sense_as_pid_fb <= 1'b0;
    end else begin
      warning_active <= next_warning;
      fault_output <= next_fault;
      stop_style <= next_stop;
      overheat_warning_indication <= next_warning && next_flash;
      overheat_fault_indication <= next_fault && next_flash;
      setting_conflict_error <= next_conflict && next_flash;
      sense_as_freq_ref <= next_prot == PROT_OFF;
      sense_as_pid_fb <= next_prot == PROT_OFF;
    end
  end

  // Checks; a latched fault keeps its first stop style, so only fresh faults count
  a_warn_only_no_stop: assert property (@(posedge clk) disable iff (reset)
    overheat_protect_select == PROT_WARN_ONLY && !fault_output |=> !fault_output)
    else $error("warning-only selection stopped the motor");
  a_off_no_warn: assert property (@(posedge clk) disable iff (reset)
    overheat_protect_select == PROT_OFF |=> !warning_active)
    else $error("warning with protection off");
  a_fault_level: assert property (@(posedge clk) disable iff (reset)
    filtered > FAULT_LEVEL && !fault_output && overheat_protect_select == PROT_COAST
    |=> fault_output && stop_style == STOP_COAST)
    else $error("coast fault missing");
  a_decel2_style: assert property (@(posedge clk) disable iff (reset)
    filtered > FAULT_LEVEL && !fault_output && overheat_protect_select == PROT_DECEL2
    |=> stop_style == STOP_DECEL2)
    else $error("second deceleration not chosen");
  a_decel_style: assert property (@(posedge clk) disable iff (reset)
    filtered > FAULT_LEVEL && !fault_output && overheat_protect_select == PROT_DECEL
    |=> stop_style == STOP_DECEL)
    else $error("deceleration not chosen");
  a_quiet_no_warn: assert property (@(posedge clk) disable iff (reset)
    overheat_protect_select >= PROT_QUIET_DECEL |=> !warning_active)
    else $error("warning shown in quiet selection");
  a_fref_refused: assert property (@(posedge clk) disable iff (reset)
    set_write && set_id == SET_FREQ_REF && overheat_protect_select != PROT_OFF
    && set_value == 4'h3 |=> $stable(freq_ref_source_select) && (panel_error || conflict_held))
    else $error("analog reference accepted with protection on");
  a_pidfb_refused: assert property (@(posedge clk) disable iff (reset)
    set_write && set_id == SET_PID_FB && overheat_protect_select != PROT_OFF
    && pid_control_select != 4'h0 && set_value == 4'h1
    |=> $stable(pid_feedback_source_select))
    else $error("analog feedback accepted with protection on");
  a_filter_range: assert property (@(posedge clk) disable iff (reset)
    overheat_filter_time <= 7'(FILTER_TIME_MAX))
    else $error("filter time out of range");
endmodule : motor_overheat_supervisor

// ==== overheat_filter.sv ====
/*
  First-order filter of the overheat sense sample.
  Assumes a step tick every 0.1 s; time constant in tenths of a second.
*/
module overheat_filter
  import overheat_pkg::*;
(
  input wire logic clk, // 100 MHz
  input wire logic reset, // Synchronous, active high
  input wire logic step, // One pulse per 0.1 s
  input wire logic [SAMPLE_W-1:0] sample, // Raw sense value
  input wire logic [6:0] time_const, // Tenths of a second
  output logic [SAMPLE_W-1:0] filtered // Registered filter output
);
  logic [SAMPLE_W+6:0] acc;
  logic [SAMPLE_W+6:0] next_acc;
  logic [SAMPLE_W-1:0] next_filtered;

  // Exponential step: acc += (sample - acc/(tc+1)); zero time passes straight
  always_comb begin
    next_acc = acc;
    next_filtered = filtered;
    if (time_const == 7'h00) begin
      next_acc = {7'h00, sample};
      next_filtered = sample;
    end else if (step) begin
      next_acc = acc - (SAMPLE_W+7)'(acc / ({10'h000, time_const} + 17'h0_0001))
        + {7'h00, sample};
      next_filtered = SAMPLE_W'(next_acc / ({10'h000, time_const} + 17'h0_0001));
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      acc <= '0;
      filtered <= '0;
    end else begin
      acc <= next_acc;
      filtered <= next_filtered;
    end
  end
endmodule : overheat_filter

// ==== overheat_pkg.sv ====
/*
  Constants for the motor overheat supervisor: thresholds, selection codes,
  filter timing and setting-check codes.
  Assumes a 100 MHz clock and a 10-bit sense sample scaled 0 to 10 V.
*/
package overheat_pkg;
  // Clock and filter timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int FILTER_STEP_MS = 100; // One filter step is 0.1 s
  localparam int FILTER_STEP_CYCLES = FILTER_STEP_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int SAMPLE_W = 10;
  localparam int SETTING_W = 4;
  localparam int FILTER_TIME_MAX = 100; // 10.0 s in 0.1 s steps
  localparam logic [6:0] FILTER_TIME_RESET = 7'h02; // 0.2 s
  localparam int VOLT_FULL_MV = 10_000;
  localparam int WARN_MV = 940;
  localparam int FAULT_MV = 1870;
  localparam logic [SAMPLE_W-1:0] WARN_LEVEL = SAMPLE_W'(WARN_MV * 1023 / VOLT_FULL_MV);
  localparam logic [SAMPLE_W-1:0] FAULT_LEVEL = SAMPLE_W'(FAULT_MV * 1023 / VOLT_FULL_MV);
  // Protection selection codes
  localparam logic [3:0] PROT_OFF = 4'h0;
  localparam logic [3:0] PROT_WARN_ONLY = 4'h1;
  localparam logic [3:0] PROT_DECEL = 4'h2;
  localparam logic [3:0] PROT_DECEL2 = 4'h3;
  localparam logic [3:0] PROT_COAST = 4'h4;
  localparam logic [3:0] PROT_QUIET_DECEL = 4'h5;
  localparam logic [3:0] PROT_QUIET_DECEL2 = 4'h6;
  localparam logic [3:0] PROT_QUIET_COAST = 4'h7;
  localparam logic [3:0] PROT_RESET = 4'h0;
  // Setting identifiers for the write port
  localparam logic [1:0] SET_PROTECT = 2'h0;
  localparam logic [1:0] SET_FREQ_REF = 2'h1;
  localparam logic [1:0] SET_PID_CTRL = 2'h2;
  localparam logic [1:0] SET_PID_FB = 2'h3;
  localparam logic [3:0] FREQ_REF_RESET = 4'h0;
  localparam logic [3:0] PID_CTRL_RESET = 4'h0;
  localparam logic [3:0] PID_FB_RESET = 4'h0;
  // Stop styles
  typedef enum logic [1:0] {STOP_NONE, STOP_DECEL, STOP_DECEL2, STOP_COAST} stop_style_t;
  // Flash blink half period, 0.5 s at the filter tick rate
  localparam logic [2:0] FLASH_TICKS = 3'h5;
endpackage : overheat_pkg

// ==== ptc_chain_model.sv ====
/*
  Behavioural model of the thermistor chain and its converter.
  Assumes the bench sets the chain voltage code; output moves on clk.
*/
module ptc_chain_model
  import overheat_pkg::*;
(
  input wire logic clk, // Bench clock
  input wire logic [SAMPLE_W-1:0] chain_level, // Chain voltage code
  output logic [SAMPLE_W-1:0] sense // Digitised sense value
);
  // Known level at time zero so the sense input is never unknown
  initial sense = '0;
  // One-cycle converter delay, like a sampled analog input
  always @(posedge clk) begin
    sense <= chain_level;
  end
endmodule : ptc_chain_model

// ==== tb_top.sv ====
/*
  Self-checking bench for the overheat supervisor.
  Assumes the package constants and a chain model on the sense input.
*/
module tb_top
  import overheat_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, set_write, set_from_serial, set_filter_write, error_clear;
  logic [1:0] set_id, stop_style;
  logic [3:0] set_value, prot, fref, pidc, pidfb;
  logic [6:0] set_filter_time, ftime;
  logic [9:0] level, sense;
  logic warn_ind, fault_ind, warning_active, fault_output, panel_error, conflict;
  logic as_ref, as_fb;
  int fail_count, checked;
  logic [31:0] seed = 32'h6ab1_62ea;
  ptc_chain_model ptc_chain_model_i (.clk(clk), .chain_level(level), .sense(sense));
  motor_overheat_supervisor motor_overheat_supervisor_i (
    .clk(clk), .reset(reset), .overheat_sense_input(sense), .set_write(set_write),
    .set_from_serial(set_from_serial), .set_id(set_id), .set_value(set_value),
    .set_filter_time(set_filter_time), .set_filter_write(set_filter_write),
    .error_clear(error_clear), .overheat_warning_indication(warn_ind),
    .overheat_fault_indication(fault_ind), .warning_active(warning_active),
    .fault_output(fault_output), .stop_style(stop_style), .panel_error(panel_error),
    .setting_conflict_error(conflict), .sense_as_freq_ref(as_ref), .sense_as_pid_fb(as_fb),
    .overheat_protect_select(prot), .freq_ref_source_select(fref),
    .pid_control_select(pidc), .pid_feedback_source_select(pidfb),
    .overheat_filter_time(ftime));
  // Free-running 100 MHz clock
  initial clk = 1'b0;
  always #5 clk = ~clk;
  // Expected outcomes from selection code and level
  function automatic logic f_warn(input int s, input int v);
    return s >= 1 && s <= 4 && v > int'(WARN_LEVEL);
  endfunction : f_warn
  function automatic logic f_fault(input int s, input int v);
    return s >= 2 && s <= 7 && v > int'(FAULT_LEVEL);
  endfunction : f_fault
  function automatic logic [1:0] f_stop(input int s);
    return (s < 2) ? 2'h0 : 2'((s - 2) % 3 + 1);
  endfunction : f_stop
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task chk(input string name, input logic [9:0] exp, input logic [9:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk
  // Inputs move 1 ns after the edge so sampling never races
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task do_reset;
    reset = 1'b1;
    cyc(5);
    reset = 1'b0;
  endtask : do_reset
  task wr(input logic [1:0] id, input logic [3:0] v, input logic ser);
    set_write = 1'b1;
    set_id = id;
    set_value = v;
    set_from_serial = ser;
    cyc(1);
    set_write = 1'b0;
    cyc(1);
  endtask : wr
  task filt(input logic [6:0] t);
    set_filter_time = t;
    set_filter_write = 1'b1;
    cyc(1);
    set_filter_write = 1'b0;
    cyc(1);
  endtask : filt
  task results;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results
  // Watchdog; the whole run needs well under 5000 cycles
  initial begin
    #500_000;
    fail_count++;
    results();
  end
  // Main sequence
  initial begin
    {set_write, set_from_serial, set_filter_write, error_clear} = 4'h0;
    {set_id, set_value, set_filter_time, level} = '0;
    do_reset();
    chk("filter_time", 10'h2, 10'(ftime));
    chk("protect", 10'h0, 10'(prot));
    // Every selection code with a level above both thresholds
    for (int s = 0; s < 8; s++) begin
      do_reset();
      filt(7'h00);
      wr(SET_PROTECT, 4'(s), 1'b0);
      level = 10'h0fa;
      cyc(6);
      chk("warning", 10'(f_warn(s, 250)), 10'(warning_active));
      chk("fault", 10'(f_fault(s, 250)), 10'(fault_output));
      chk("stop", 10'(f_stop(s)), 10'(stop_style));
      chk("as_ref", 10'(s == 0), 10'(as_ref));
      chk("as_fb", 10'(s == 0), 10'(as_fb));
      // Lamps are dark for the first half second of the flash cycle after reset
      chk("warn_lamp", 10'h0, 10'(warn_ind));
      chk("fault_lamp", 10'h0, 10'(fault_ind));
      level = 10'h000;
      cyc(6);
      chk("fault_held", 10'(f_fault(s, 250)), 10'(fault_output));
    end
    // Threshold edges, strictly greater
    do_reset();
    filt(7'h00);
    wr(SET_PROTECT, PROT_DECEL, 1'b0);
    for (int v = 0; v < 4; v++) begin
      level = (v < 2) ? 10'(96 + v) : 10'(189 + v);
      cyc(6);
      chk("warn_edge", 10'(f_warn(2, int'(level))), 10'(warning_active));
      chk("fault_edge", 10'(f_fault(2, int'(level))), 10'(fault_output));
    end
    // A one-cycle spike must not pass the default filter
    do_reset();
    wr(SET_PROTECT, PROT_COAST, 1'b0);
    level = 10'h3ff;
    cyc(1);
    level = 10'h000;
    cyc(10);
    chk("spike_fault", 10'h0, 10'(fault_output));
    filt(7'd101);
    chk("filter_over", 10'h2, 10'(ftime));
    filt(7'd100);
    chk("filter_max", 10'd100, 10'(ftime));
    // Random levels, warning-only selection
    do_reset();
    filt(7'h00);
    wr(SET_PROTECT, PROT_WARN_ONLY, 1'b0);
    repeat (40) begin
      seed = lfsr(seed);
      level = seed[9:0];
      cyc(6);
      chk("rand_warn", 10'(f_warn(1, int'(level))), 10'(warning_active));
      chk("rand_fault", 10'h0, 10'(fault_output));
    end
    level = 10'h000;
    // Refused settings while protection is on
    do_reset();
    wr(SET_PROTECT, PROT_DECEL, 1'b0);
    wr(SET_FREQ_REF, 4'h5, 1'b0);
    for (int v = 2; v < 5; v++) begin
      wr(SET_FREQ_REF, 4'(v), 1'b0);
      chk("ref_kept", 10'h5, 10'(fref));
      chk("panel_err", 10'h1, 10'(panel_error));
    end
    error_clear = 1'b1;
    cyc(1);
    error_clear = 1'b0;
    cyc(1);
    chk("err_clear", 10'h0, 10'(panel_error));
    wr(SET_FREQ_REF, 4'h3, 1'b1);
    chk("ref_serial", 10'h5, 10'(fref));
    chk("panel_quiet", 10'h0, 10'(panel_error));
    chk("conflict_dark", 10'h0, 10'(conflict));
    wr(SET_PID_CTRL, 4'h1, 1'b0);
    wr(SET_PID_FB, 4'h3, 1'b0);
    chk("fb_ok", 10'h3, 10'(pidfb));
    for (int v = 0; v < 3; v++) begin
      wr(SET_PID_FB, 4'(v), 1'b0);
      chk("fb_kept", 10'h3, 10'(pidfb));
    end
    wr(SET_PROTECT, 4'h8, 1'b0);
    chk("prot_over", 10'h2, 10'(prot));
    // Conflicting combination blocks selection 1
    do_reset();
    wr(SET_FREQ_REF, 4'h2, 1'b0);
    wr(SET_PID_CTRL, 4'h1, 1'b0);
    wr(SET_PID_FB, 4'h0, 1'b0);
    wr(SET_PROTECT, PROT_WARN_ONLY, 1'b0);
    chk("prot_block", 10'h0, 10'(prot));
    chk("block_err", 10'h1, 10'(panel_error));
    results();
  end
endmodule : tb_top
